// ===== hdl/fan_ctrl_pkg.sv
// shared constants and types for the fan drive supervisory block
// assumes a 125 MHz system clock and byte-wide register transactions
package fan_ctrl_pkg;

  localparam int NUM_CH = 3;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [2:0][7:0] OFS_DUTY = {8'h32, 8'h31, 8'h30};
  localparam logic [2:0][7:0] OFS_CFG = {8'h5e, 8'h5d, 8'h5c};
  localparam logic [7:0] OFS_START_TEMP_CTRL1 = 8'h36;
  localparam logic [7:0] OFS_TEST_TREE = 8'h6f;
  localparam logic [7:0] OFS_CFG2 = 8'h73;

  //////////////////////////////////////////////////////////////////////////////
  // reset values and field positions
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h82;
  localparam logic [7:0] START_TEMP_RST = 8'h00;
  localparam logic TEST_TREE_RST = 1'b0;
  localparam int GUARD_BIT = 1;
  localparam int TREE_EN_BIT = 0;
  localparam int DET_START_BIT = 0;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] DUTY_OFF = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int FAILSAFE_TIME_MS = 4600;
  localparam int FAILSAFE_CYCLES = FAILSAFE_TIME_MS * CLK_FREQ_KHZ;
  localparam int DETECT_TIME_US = 5000;
  localparam int DETECT_CYCLES = (DETECT_TIME_US * CLK_FREQ_KHZ + 999) / 1000;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    BHV_REMOTE1 = 3'b000,
    BHV_LOCAL = 3'b001,
    BHV_REMOTE2 = 3'b010,
    BHV_FULL = 3'b011,
    BHV_OFF = 3'b100,
    BHV_FAST_LR2 = 3'b101,
    BHV_FAST_ALL = 3'b110,
    BHV_MANUAL = 3'b111
  } fan_behaviour_select_t;

  typedef struct packed {
    fan_behaviour_select_t fan_behaviour_select;
    logic invert;
    logic rsvd;
    logic [2:0] spin;
  } fan_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ===== hdl/fan_pwm_gen.sv
// one pwm channel: free running phase counter compared against a duty code
// assumes duty and invert are stable register outputs of the caller
`timescale 1ns/10ps
module fan_pwm_gen #(
  parameter int DIV_W = 4
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] duty_i,
  input wire logic invert_i,
  input wire logic release_i,
  output logic pin_o,
  output logic pin_oe_n_o
);
  import fan_ctrl_pkg::*;

  logic [DIV_W-1:0] pre_q;
  logic [7:0] phase_q;

  // prescaler sets the period; phase steps once per prescaler wrap
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_q <= '0;
      phase_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 1'b1;
      if (&pre_q) begin
        phase_q <= phase_q + 8'h01;
      end
    end
  end

  // active for duty/256 of the period, code 0 never active
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b0;
    end else begin
      pin_o <= (phase_q < duty_i) ^ invert_i;
      pin_oe_n_o <= release_i; // let go of the pin while sensing
    end
  end

  AST_PWM_ZERO_IDLE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (duty_i == 8'h00 && !invert_i) |=> !pin_o)
    else $error("pwm active with zero duty");

endmodule

// ===== hdl/fan_failsafe_timer.sv
// power-on fail-safe: forces full fan drive if the core rail is high at power-up and nobody addresses the part
// assumes addressed_i is a one-cycle pulse per valid addressed transaction
`timescale 1ns/10ps
module fan_failsafe_timer #(
  parameter int TIMEOUT = fan_ctrl_pkg::FAILSAFE_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic rail_high_i,
  input wire logic addressed_i,
  output logic force_full_o,
  output logic restore_o
);
  import fan_ctrl_pkg::*;

  localparam int CNT_W = $clog2(TIMEOUT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT - 1);

  typedef enum logic [1:0] {
    FS_SAMPLE = 2'b00,
    FS_COUNT = 2'b01,
    FS_FORCED = 2'b10,
    FS_NORMAL = 2'b11
  } fs_state_t;

  fs_state_t state_q;
  logic [CNT_W-1:0] cnt_q;

  // rail level is caught on the first edge after reset, never by the reset
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= FS_SAMPLE;
    end else begin
      unique case (state_q)
        FS_SAMPLE: state_q <= rail_high_i ? FS_COUNT : FS_NORMAL;
        FS_COUNT: begin
          if (addressed_i) begin
            state_q <= FS_NORMAL;
          end else if (cnt_q == CNT_LAST) begin
            state_q <= FS_FORCED;
          end
        end
        FS_FORCED: begin
          if (addressed_i) begin
            state_q <= FS_NORMAL;
          end
        end
        FS_NORMAL: state_q <= FS_NORMAL;
      endcase
    end
  end

  // timeout counter only runs while waiting for the host
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else if (state_q == FS_COUNT) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // outputs registered; restore is a single pulse on leaving forced drive
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      force_full_o <= 1'b0;
      restore_o <= 1'b0;
    end else begin
      force_full_o <= (state_q == FS_COUNT && cnt_q == CNT_LAST && !addressed_i)
                      || (state_q == FS_FORCED && !addressed_i);
      restore_o <= (state_q == FS_FORCED) && addressed_i;
    end
  end

  AST_FS_RELEASE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == FS_FORCED && addressed_i) |=> (!force_full_o && restore_o))
    else $error("forced drive not released on address");
  AST_FS_EARLY: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_q == FS_COUNT && addressed_i) |=> (state_q == FS_NORMAL && !force_full_o))
    else $error("early address did not cancel timer");
  COV_FS_EXPIRE: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(force_full_o));

endmodule

// ===== hdl/fan_pwm_manual_failsafe_ctrl.sv
// fan drive supervisor: duty registers, behaviour mux, presence sensing,
// core rail guard, board test tree and power-on fail-safe
// assumes an external smbus engine delivering decoded byte transactions
`timescale 1ns/10ps

module fan_pwm_manual_failsafe_ctrl #(
  parameter int DETECT_CYCLES_P = fan_ctrl_pkg::DETECT_CYCLES,
  parameter int FAILSAFE_CYCLES_P = fan_ctrl_pkg::FAILSAFE_CYCLES,
  parameter int TREE_W = 8,
  parameter int PWM_DIV_W = 4
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input fan_ctrl_pkg::reg_req_t reg_req_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic smbus_addressed_i,
  input wire logic [2:0][7:0] temp_duty_i,
  input wire logic cpu_core_rail_input_high_i,
  input wire logic cpu_core_rail_input_low_i,
  input wire logic core_status_clr_i,
  input wire logic alert_core_rail_en_i,
  output logic core_rail_low_status_o,
  output logic smbalert_n_o,
  output logic thermal_throttle_pin_monitor_en_o,
  output logic thermal_throttle_pin_timer_hold_o,
  output logic fan_start_temperature_adjust_en_o,
  output logic shutdown_allow_o,
  output logic [2:0] fan_drive_out_o,
  output logic [2:0] fan_drive_out_oe_n_o,
  input wire logic [2:0] fan_drive_out_i,
  output logic [2:0] fan_sink_en_o,
  input wire logic [TREE_W-1:0] tree_pins_i,
  output logic board_test_tree_en_o,
  output logic tree_out_o,
  output logic fans_forced_o
);
  import fan_ctrl_pkg::*;

  localparam int DET_W = $clog2(DETECT_CYCLES_P + 1);
  localparam logic [DET_W-1:0] DET_LAST = DET_W'(DETECT_CYCLES_P - 1);

  typedef enum logic {
    DET_IDLE = 1'b0,
    DET_RUN = 1'b1
  } det_state_t;

  fan_cfg_t cfg_q [NUM_CH];
  logic [7:0] duty_q [NUM_CH];
  logic [7:0] live_q [NUM_CH];
  logic [7:0] start_temp_q;
  logic tree_en_q;
  det_state_t det_q;
  logic [DET_W-1:0] det_cnt_q;
  logic [2:0] presence_q;
  logic restore;
  logic fans_forced;
  logic det_start;
  logic low_evt;
  logic status_d;
  logic [7:0] rd_mux;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] max2(input logic [7:0] a, input logic [7:0] b);
    max2 = (a > b) ? a : b;
  endfunction

  // behaviour mux; auto duties come from the temperature loop outside
  function automatic logic [7:0] pick_duty(
    input fan_behaviour_select_t bhv,
    input logic [7:0] manual,
    input logic [2:0][7:0] t
  );
    unique case (bhv)
      BHV_REMOTE1: pick_duty = t[0];
      BHV_LOCAL: pick_duty = t[1];
      BHV_REMOTE2: pick_duty = t[2];
      BHV_FULL: pick_duty = DUTY_FULL;
      BHV_OFF: pick_duty = DUTY_OFF;
      BHV_FAST_LR2: pick_duty = max2(t[1], t[2]);
      BHV_FAST_ALL: pick_duty = max2(t[0], max2(t[1], t[2]));
      BHV_MANUAL: pick_duty = manual;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // fail-safe timer

  fan_failsafe_timer #(
    .TIMEOUT(FAILSAFE_CYCLES_P)
  ) u_failsafe (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .rail_high_i(cpu_core_rail_input_high_i),
    .addressed_i(smbus_addressed_i),
    .force_full_o(fans_forced),
    .restore_o(restore)
  );

  assign fans_forced_o = fans_forced;

  //////////////////////////////////////////////////////////////////////////////
  // per channel registers, live duty and pwm

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    // behaviour and polarity; restore returns to power-on values
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cfg_q[c] <= fan_cfg_t'(CFG_RST);
      end else if (restore) begin
        cfg_q[c] <= fan_cfg_t'(CFG_RST);
      end else if (reg_req_i.wr && reg_req_i.addr == OFS_CFG[c]) begin
        cfg_q[c] <= fan_cfg_t'(reg_req_i.wdata);
      end
    end

    // manual duty; writes outside manual mode are dropped silently
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        duty_q[c] <= DUTY_RST;
      end else if (restore) begin
        duty_q[c] <= DUTY_RST;
      end else if (reg_req_i.wr && reg_req_i.addr == OFS_DUTY[c]
                   && cfg_q[c].fan_behaviour_select == BHV_MANUAL) begin
        duty_q[c] <= reg_req_i.wdata;
      end
    end

    // duty actually driven; fail-safe overrides every behaviour
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        live_q[c] <= DUTY_RST;
      end else if (fans_forced) begin
        live_q[c] <= DUTY_FULL;
      end else begin
        live_q[c] <= pick_duty(cfg_q[c].fan_behaviour_select, duty_q[c], temp_duty_i);
      end
    end

    fan_pwm_gen #(
      .DIV_W(PWM_DIV_W)
    ) u_pwm (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .duty_i(live_q[c]),
      .invert_i(cfg_q[c].invert),
      .release_i(det_q == DET_RUN),
      .pin_o(fan_drive_out_o[c]),
      .pin_oe_n_o(fan_drive_out_oe_n_o[c])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // start-temperature control and test tree registers

  // only the guard bit acts here; other bits are kept for the host
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_temp_q <= START_TEMP_RST;
    end else if (restore) begin
      start_temp_q <= START_TEMP_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == OFS_START_TEMP_CTRL1) begin
      start_temp_q <= reg_req_i.wdata;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tree_en_q <= TEST_TREE_RST;
    end else if (restore) begin
      tree_en_q <= TEST_TREE_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == OFS_TEST_TREE) begin
      tree_en_q <= reg_req_i.wdata[TREE_EN_BIT];
    end
  end

  assign board_test_tree_en_o = tree_en_q;

  // xnor chain over the participating pins, parked low outside test mode
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tree_out_o <= 1'b0;
    end else begin
      tree_out_o <= tree_en_q & ~^tree_pins_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fan presence sensing

  // host is expected to have set full duty and to wait before reading
  assign det_start = reg_req_i.wr && reg_req_i.addr == OFS_CFG2
                     && reg_req_i.wdata[DET_START_BIT] && det_q == DET_IDLE;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      det_q <= DET_IDLE;
      det_cnt_q <= '0;
    end else begin
      unique case (det_q)
        DET_IDLE: begin
          det_cnt_q <= '0;
          if (det_start) begin
            det_q <= DET_RUN;
          end
        end
        DET_RUN: begin
          det_cnt_q <= det_cnt_q + 1'b1;
          if (det_cnt_q == DET_LAST) begin
            det_q <= DET_IDLE;
          end
        end
      endcase
    end
  end

  // pin level sampled at the end of the window, high means fan present
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      presence_q <= 3'h0;
    end else if (det_q == DET_RUN && det_cnt_q == DET_LAST) begin
      presence_q <= fan_drive_out_i;
    end
  end

  // sink enabled for the whole window while the driver is released
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fan_sink_en_o <= 3'h0;
    end else begin
      fan_sink_en_o <= {3{det_q == DET_RUN}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core rail guard

  assign low_evt = start_temp_q[GUARD_BIT] && cpu_core_rail_input_low_i;
  // a new low event beats a clear in the same cycle
  assign status_d = low_evt || (core_rail_low_status_o && !core_status_clr_i);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core_rail_low_status_o <= 1'b0;
      smbalert_n_o <= 1'b1;
    end else begin
      core_rail_low_status_o <= status_d;
      smbalert_n_o <= !(status_d && alert_core_rail_en_i);
    end
  end

  // dependent functions follow the guarded level, so they resume at once
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      thermal_throttle_pin_monitor_en_o <= 1'b1;
      thermal_throttle_pin_timer_hold_o <= 1'b0;
      fan_start_temperature_adjust_en_o <= 1'b1;
      shutdown_allow_o <= 1'b1;
    end else begin
      thermal_throttle_pin_monitor_en_o <= !low_evt;
      thermal_throttle_pin_timer_hold_o <= low_evt;
      fan_start_temperature_adjust_en_o <= !low_evt;
      shutdown_allow_o <= !low_evt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register readback

  // duty offsets read the driven value, not the stored manual value
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      if (reg_req_i.addr == OFS_DUTY[i]) begin
        rd_mux = live_q[i];
      end
      if (reg_req_i.addr == OFS_CFG[i]) begin
        rd_mux = cfg_q[i];
      end
    end
    if (reg_req_i.addr == OFS_START_TEMP_CTRL1) begin
      rd_mux = start_temp_q;
    end
    if (reg_req_i.addr == OFS_TEST_TREE) begin
      rd_mux = {7'h00, tree_en_q};
    end
    if (reg_req_i.addr == OFS_CFG2) begin
      rd_mux = {4'h0, presence_q, det_q == DET_RUN};
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        rd_data_o <= rd_mux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_MANUAL_FOLLOW: assert property (
    (cfg_q[0].fan_behaviour_select == BHV_MANUAL && !fans_forced)
    |=> live_q[0] == $past(duty_q[0]))
    else $error("manual channel not following duty");
  AST_WRITE_BLOCKED: assert property (
    (reg_req_i.wr && reg_req_i.addr == OFS_DUTY[0] && !restore
     && cfg_q[0].fan_behaviour_select != BHV_MANUAL)
    |=> $stable(duty_q[0]))
    else $error("duty written outside manual mode");
  AST_READ_LIVE: assert property (
    (reg_req_i.rd && reg_req_i.addr == OFS_DUTY[1])
    |=> (rd_valid_o && rd_data_o == $past(live_q[1])))
    else $error("duty readback differs from driven duty");
  AST_DETECT_RUNS: assert property (
    det_start |=> (det_q == DET_RUN)[*8])
    else $error("presence window ended early");
  AST_DETECT_RESULT: assert property (
    $fell(det_q == DET_RUN) |-> presence_q == $past(fan_drive_out_i))
    else $error("presence bits not loaded from pins");
  AST_SINK_ON: assert property (
    (det_q == DET_RUN) |=> (fan_sink_en_o == 3'h7 && fan_drive_out_oe_n_o == 3'h7))
    else $error("sink or release missing during sensing");
  AST_RAIL_STATUS: assert property (
    low_evt |=> core_rail_low_status_o)
    else $error("rail low status not set");
  AST_ALERT_GATED: assert property (
    (!alert_core_rail_en_i || !status_d) |=> smbalert_n_o)
    else $error("alert raised while disabled");
  AST_THROTTLE_HOLD: assert property (
    low_evt |=> (!thermal_throttle_pin_monitor_en_o && thermal_throttle_pin_timer_hold_o))
    else $error("throttle monitoring not held");
  AST_FREEZE: assert property (
    low_evt |=> (!fan_start_temperature_adjust_en_o && !shutdown_allow_o))
    else $error("adjust or shutdown not blocked");
  AST_RESUME: assert property (
    $fell(low_evt) |=> (thermal_throttle_pin_monitor_en_o && shutdown_allow_o
                        && fan_start_temperature_adjust_en_o))
    else $error("functions not resumed after rail recovery");
  AST_TREE_MODE: assert property (
    (reg_req_i.wr && reg_req_i.addr == OFS_TEST_TREE && !restore)
    |=> board_test_tree_en_o == $past(reg_req_i.wdata[TREE_EN_BIT]))
    else $error("test tree enable not taken");
  AST_FORCED_FULL: assert property (
    fans_forced |=> (live_q[0] == DUTY_FULL && live_q[2] == DUTY_FULL))
    else $error("forced drive not at full duty");

  COV_MANUAL_WRITE: cover property (
    reg_req_i.wr && reg_req_i.addr == OFS_DUTY[0]
    && cfg_q[0].fan_behaviour_select == BHV_MANUAL);
  COV_DETECT_DONE: cover property ($fell(det_q == DET_RUN));
  COV_RAIL_LOW: cover property ($rose(core_rail_low_status_o));
  COV_RESTORE: cover property (restore);

endmodule

// ===== verif/fan_host_model.sv
// host stand-in: issues decoded byte transactions and address pulses
// assumes the block takes a request on the rising edge where it is high
`timescale 1ns/10ps
module fan_host_model (
  input wire logic sys_clk_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  output fan_ctrl_pkg::reg_req_t req_o,
  output logic addressed_o
);
  import fan_ctrl_pkg::*;
  ////////////////////////////////////////
  // idle bus from time zero
  initial begin
    req_o = '0;
    addressed_o = 1'b0;
  end
  // one-cycle write pulse, dropped at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req_o <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_i);
    req_o <= '0;
  endtask
  // read; data is taken at the edge where its valid strobe is seen, else unknown
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    req_o <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_i);
    req_o <= '0;
    @(posedge sys_clk_i);
    d = rd_valid_i ? rd_data_i : 8'hxx;
  endtask
  // a valid smbus transaction addressed the part
  task automatic hit();
    @(posedge sys_clk_i);
    addressed_o <= 1'b1;
    @(posedge sys_clk_i);
    addressed_o <= 1'b0;
  endtask
endmodule

// ===== verif/fan_pwm_manual_failsafe_ctrl_tb.sv
// self-checking bench for the fan drive supervisor
// assumes the host stand-in model; fans are modelled by pull-ups here
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module fan_pwm_manual_failsafe_ctrl_tb;
  import fan_ctrl_pkg::*;
  localparam int DET = 16;
  localparam int FS = 50;
  logic clk = 1'b0, nrst = 1'b0, adr, rv, hi = 1'b1, lo = 1'b0, clr = 1'b0, aen = 1'b0;
  logic st, an, mon, hold, adj, allow, ten, tout, forced;
  logic [7:0] rdat, d, ex, tree = '0;
  logic [2:0][7:0] temp = '0;
  logic [2:0] pin, oe_n, pin_in, sink, mask = '0;
  reg_req_t req;
  int fails = 0, cmp_count = 0, n, cnt[3], man[3];
  ////////////////////////////////////////
  // clock, fan pull-ups show through only while the pin is released
  always #4 clk = ~clk;
  assign pin_in = (oe_n & mask) | (~oe_n & pin);
  fan_host_model u_host (.sys_clk_i(clk), .rd_valid_i(rv), .rd_data_i(rdat), .req_o(req),
    .addressed_o(adr));
  fan_pwm_manual_failsafe_ctrl #(.DETECT_CYCLES_P(DET), .FAILSAFE_CYCLES_P(FS), .TREE_W(8),
    .PWM_DIV_W(1)) u_dut (.sys_clk_i(clk), .nrst_i(nrst), .reg_req_i(req),
    .rd_data_o(rdat), .rd_valid_o(rv), .smbus_addressed_i(adr), .temp_duty_i(temp),
    .cpu_core_rail_input_high_i(hi), .cpu_core_rail_input_low_i(lo),
    .core_status_clr_i(clr), .alert_core_rail_en_i(aen), .core_rail_low_status_o(st),
    .smbalert_n_o(an), .thermal_throttle_pin_monitor_en_o(mon),
    .thermal_throttle_pin_timer_hold_o(hold), .fan_start_temperature_adjust_en_o(adj),
    .shutdown_allow_o(allow), .fan_drive_out_o(pin), .fan_drive_out_oe_n_o(oe_n),
    .fan_drive_out_i(pin_in), .fan_sink_en_o(sink), .tree_pins_i(tree),
    .board_test_tree_en_o(ten), .tree_out_o(tout), .fans_forced_o(forced));
  // reference duty per behaviour code
  function automatic int live(int b, int m);
    case (b)
      0, 1, 2: return temp[b];
      3: return 255;
      5: return temp[1] > temp[2] ? temp[1] : temp[2];
      6: return live(5, m) > temp[0] ? live(5, m) : temp[0];
      7: return m;
      default: return 0;
    endcase
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard, far beyond the fewer than two thousand cycles needed
  initial begin
    #(40000 * 8);
    fails++;
    end_sim();
  end
  // main sequence
  initial begin
    void'($urandom(46));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    n = 0;
    while (forced !== 1'b1 && n < 4 * FS) begin
      @(posedge clk);
      n++;
    end
    // one edge samples the rail, FS counting edges, one edge to see the flag
    `CHK(n, FS + 2)
    u_host.rd(OFS_DUTY[0], d);
    `CHK(d, DUTY_FULL)
    u_host.hit();
    repeat (3) @(posedge clk);
    `CHK(forced, 1'b0)
    u_host.rd(OFS_CFG[0], d);
    `CHK(d, CFG_RST)
    for (int c = 0; c < 3; c++) begin
      u_host.rd(OFS_DUTY[c], d);
      `CHK(d, DUTY_RST)
    end
    u_host.wr(OFS_DUTY[0], 8'h5a);
    u_host.rd(OFS_DUTY[0], d);
    `CHK(d, 8'h00)
    u_host.rd(8'h10, d);
    `CHK(d, 8'h00)
    temp <= {8'($urandom), 8'($urandom), 8'($urandom)};
    for (int b = 0; b < 8; b++) begin
      for (int c = 0; c < 3; c++) begin
        u_host.wr(OFS_CFG[c], {3'(b), 5'h02});
        ex = 8'($urandom);
        man[c] = ex;
        u_host.wr(OFS_DUTY[c], ex);
        u_host.rd(OFS_DUTY[c], d);
        `CHK(d, 8'(live(b, ex)))
      end
    end
    // duty over one full 512-cycle period, any phase; a phase step lasts two clocks
    repeat (600) @(posedge clk);
    cnt = '{0, 0, 0};
    repeat (512) begin
      @(negedge clk);
      foreach (cnt[c]) cnt[c] += pin[c];
    end
    foreach (cnt[c]) `CHK(cnt[c], man[c] * 2)
    @(posedge clk);
    mask <= 3'($urandom);
    for (int c = 0; c < 3; c++) u_host.wr(OFS_CFG[c], 8'h62);
    u_host.wr(OFS_CFG2, 8'h01);
    repeat (4) @(posedge clk);
    `CHK(sink, 3'h7)
    repeat (DET + 4) @(posedge clk);
    u_host.rd(OFS_CFG2, d);
    `CHK(d, {4'h0, mask, 1'b0})
    u_host.wr(OFS_START_TEMP_CTRL1, 8'h02);
    for (int e = 0; e < 2; e++) begin
      aen <= e[0];
      lo <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK({st, an, mon, hold, adj, allow}, {1'b1, !e[0], 4'b0100})
      lo <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK({st, mon, hold, adj, allow}, 5'b11011)
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK({st, an}, 2'b01)
    end
    u_host.wr(OFS_TEST_TREE, 8'h01);
    tree <= 8'($urandom);
    repeat (3) @(posedge clk);
    `CHK({ten, tout}, {1'b1, ~^tree})
    // second power-up, addressed early: never forced
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    u_host.hit();
    repeat (2 * FS) @(posedge clk);
    `CHK(forced, 1'b0)
    u_host.rd(OFS_CFG[1], d);
    `CHK(d, CFG_RST)
    // third power-up with the core rail low: the timer never runs
    hi <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2 * FS) @(posedge clk);
    `CHK(forced, 1'b0)
    u_host.hit();
    u_host.rd(OFS_DUTY[2], d);
    `CHK(d, DUTY_RST)
    end_sim();
  end
endmodule
